// >>> rtl/rvps_pkg.sv
/*
 * Package for the reference validation and preset select register bank.
 * Holds register offsets, field positions, reset values, scale encodings
 * and system loop setups. Assumes a byte-wide register port on clk.
 */
package rvps_pkg;
    // Register offsets
    localparam logic [11:0] ADDR_FORCE_TIMEOUT   = 12'ha0b;
    localparam logic [11:0] ADDR_MON_OVERRIDE    = 12'ha0c;
    localparam logic [11:0] ADDR_MON_BYPASS      = 12'ha0d;
    localparam logic [11:0] ADDR_SEC1_ENABLE     = 12'hc00;
    localparam logic [11:0] ADDR_FREQ_SELECT     = 12'hc01;
    localparam logic [11:0] ADDR_SYSPLL_SELECT   = 12'hc02;
    localparam logic [11:0] ADDR_SEC2_ENABLE     = 12'hc03;
    localparam logic [11:0] ADDR_REF_SCALE       = 12'hc04;
    localparam logic [11:0] ADDR_OUT_SCALE       = 12'hc05;
    localparam logic [11:0] ADDR_START_TRANSFER  = 12'hc07;
    // Field positions
    localparam int REF_FIRST_BIT   = 0;
    localparam int REF_SECOND_BIT  = 1;
    localparam int ENABLE_BIT      = 0;
    localparam int START_BIT       = 0;
    localparam int OUT_SEL_LSB     = 4;
    localparam int IN_SEL_LSB      = 0;
    localparam int SCALE_LO_LSB    = 0;
    localparam int SCALE_HI_LSB    = 2;
    // Reset values
    localparam logic [1:0] RST_TWO_BITS  = 2'h0;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [3:0] RST_NIBBLE    = 4'h0;
    // ROM download length in clock cycles
    localparam int DOWNLOAD_CYCLES = 16;
    // Scale codes
    typedef enum logic [1:0] {
        RVPS_DIV1  = 2'h0,
        RVPS_DIV4  = 2'h1,
        RVPS_DIV8  = 2'h2,
        RVPS_DIV16 = 2'h3
    } rvps_scale_type;
    localparam logic [4:0] DIV_BY_1  = 5'h01;
    localparam logic [4:0] DIV_BY_4  = 5'h04;
    localparam logic [4:0] DIV_BY_8  = 5'h08;
    localparam logic [4:0] DIV_BY_16 = 5'h10;
    // System loop setups: source kind, doubler, divider
    localparam logic [5:0] SYS_DIV_16 = 6'h10;
    localparam logic [5:0] SYS_DIV_8  = 6'h08;
    localparam logic [5:0] SYS_DIV_32 = 6'h20;
    localparam logic [1:0] SYS_SEL_CRYSTAL_RESONATOR_LOW  = 2'h0;
    localparam logic [1:0] SYS_SEL_CRYSTAL_RESONATOR_HIGH = 2'h1;
    localparam logic [1:0] SYS_SEL_OSC_LOW   = 2'h2;
    localparam logic [1:0] SYS_SEL_OSC_HIGH  = 2'h3;
    // Download engine states, Gray order
    typedef enum logic [1:0] {
        RVPS_IDLE = 2'b00,
        RVPS_LOAD = 2'b01,
        RVPS_DONE = 2'b11
    } rvps_state_type;
endpackage

// >>> rtl/rvps_bank.sv
/*
 * Register bank for reference validation control and frequency preset
 * selection. Assumes a plain byte register port on clk, a synchronous
 * active-high reset, and an asynchronous config_source_select_pin.
 */
// Summary of operation
// - Writing one to force-timeout bit validates that reference at once; self-clears.
// - Override bit ORs with monitor fault, forces reference invalid; resets to zero.
// - Overridden reference is unusable for selection; switch away when active.
// - Bypass bit skips monitor for that reference and starts its timer.
// - Section one enable defaults off; when on, active only if pin low at reset.
// - Pin high at reset selects hardware programming; section one ignored.
// - Section one picks one of 256 ROM-held frequency translations.
// - Upper select nibble picks output frequency; reloads output side values.
// - Lower select nibble picks input frequency; reloads all four input profiles.
// - Two-bit field picks one of four system loop setups from ROM.
// - Setups: crystal x2 /16, crystal x2 /8, oscillator /32, oscillator /16.
// - Section two enable defaults off; when on, active while pin is low.
// - Reference scale bits 3:2 divide second reference input by 1,4,8,16.
// - Reference scale bits 1:0 divide first reference input likewise.
// - Output scale bits 3:2 divide channel one output by 1,4,8,16.
// - Output scale bits 1:0 divide channel zero output likewise.
// - Start-transfer begins ROM download without reset; clears when done.
`timescale 1ns/10ps
module rvps_bank
    import rvps_pkg::*;
#(
    parameter int DOWNLOAD_LEN = rvps_pkg::DOWNLOAD_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        config_source_select_pin,
    input  wire logic [1:0]  monitor_fault,
    output logic      [1:0]  force_timeout_pulse,
    output logic      [1:0]  ref_fault_eff,
    output logic      [1:0]  ref_usable,
    output logic      [1:0]  monitor_bypassed,
    output logic      [1:0]  validation_timer_start,
    output logic             hard_pin_mode,
    output logic             section_one_active,
    output logic             section_two_active,
    output logic      [7:0]  translation_index,
    output logic             output_reload,
    output logic             input_reload,
    output logic             syspll_reload,
    output logic             rom_busy,
    output logic             syspll_doubler,
    output logic             syspll_crystal,
    output logic      [5:0]  syspll_divider,
    output logic      [4:0]  first_ref_divide,
    output logic      [4:0]  second_ref_divide,
    output logic      [4:0]  channel_zero_divide,
    output logic      [4:0]  channel_one_divide
);
    import rvps_pkg::*;

    logic [1:0] force_r;
    logic [1:0] override_r;
    logic [1:0] bypass_r;
    logic [1:0] bypass_d_r;
    logic       sec1_en_r;
    logic [7:0] freq_sel_r;
    logic [1:0] sys_sel_r;
    logic       sec2_en_r;
    logic [3:0] ref_scale_r;
    logic [3:0] out_scale_r;
    logic       start_r;
    logic       pin_meta_r;
    logic       pin_sync_r;
    logic       hard_pin_r;
    logic       rst_seen_r;
    logic [7:0] rdata_r;
    logic       out_rl_r;
    logic       in_rl_r;
    logic       sys_rl_r;
    logic [15:0] dl_cnt_r;
    rvps_state_type state_r;
    rvps_state_type state_nxt;

    // Decoded write strobes
    logic wr_force, wr_ovr, wr_byp, wr_en1, wr_fsel, wr_ssel, wr_en2, wr_rsc, wr_osc, wr_start;
    assign wr_force = reg_wr && reg_addr == ADDR_FORCE_TIMEOUT;
    assign wr_ovr   = reg_wr && reg_addr == ADDR_MON_OVERRIDE;
    assign wr_byp   = reg_wr && reg_addr == ADDR_MON_BYPASS;
    assign wr_en1   = reg_wr && reg_addr == ADDR_SEC1_ENABLE;
    assign wr_fsel  = reg_wr && reg_addr == ADDR_FREQ_SELECT;
    assign wr_ssel  = reg_wr && reg_addr == ADDR_SYSPLL_SELECT;
    assign wr_en2   = reg_wr && reg_addr == ADDR_SEC2_ENABLE;
    assign wr_rsc   = reg_wr && reg_addr == ADDR_REF_SCALE;
    assign wr_osc   = reg_wr && reg_addr == ADDR_OUT_SCALE;
    assign wr_start = reg_wr && reg_addr == ADDR_START_TRANSFER;

    // Pin synchroniser
    always_ff @(posedge clk) begin
        pin_meta_r <= config_source_select_pin;
        pin_sync_r <= pin_meta_r;
    end

    // Strap capture in the cycle after reset release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_seen_r <= 1'b1;
            hard_pin_r <= 1'b0;
        end else begin
            rst_seen_r <= 1'b0;
            if (rst_seen_r) begin
                hard_pin_r <= pin_sync_r;
            end
        end
    end

    // Force-timeout bits pulse one cycle then clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            force_r <= RST_TWO_BITS;
        end else if (wr_force) begin
            force_r <= reg_wdata[REF_SECOND_BIT:REF_FIRST_BIT];
        end else begin
            force_r <= RST_TWO_BITS;
        end
    end

    // Override and bypass registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            override_r <= RST_TWO_BITS;
            bypass_r   <= RST_TWO_BITS;
            bypass_d_r <= RST_TWO_BITS;
        end else begin
            bypass_d_r <= bypass_r;
            if (wr_ovr) begin
                override_r <= reg_wdata[1:0];
            end
            if (wr_byp) begin
                bypass_r <= reg_wdata[1:0];
            end
        end
    end

    // Preset selection registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sec1_en_r   <= 1'b0;
            sec2_en_r   <= 1'b0;
            freq_sel_r  <= RST_BYTE;
            sys_sel_r   <= RST_TWO_BITS;
            ref_scale_r <= RST_NIBBLE;
            out_scale_r <= RST_NIBBLE;
        end else begin
            if (wr_en1) sec1_en_r <= reg_wdata[ENABLE_BIT];
            if (wr_en2) sec2_en_r <= reg_wdata[ENABLE_BIT];
            if (wr_fsel) freq_sel_r <= reg_wdata;
            if (wr_ssel) sys_sel_r <= reg_wdata[1:0];
            if (wr_rsc) ref_scale_r <= reg_wdata[3:0];
            if (wr_osc) out_scale_r <= reg_wdata[3:0];
        end
    end

    // Reload pulses on select changes, and at download end, while section one is live
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_rl_r <= 1'b0;
            in_rl_r  <= 1'b0;
            sys_rl_r <= 1'b0;
        end else begin
            out_rl_r <= wr_fsel && section_one_active &&
                        reg_wdata[7:OUT_SEL_LSB] != freq_sel_r[7:OUT_SEL_LSB];
            in_rl_r  <= wr_fsel && section_one_active &&
                        reg_wdata[3:IN_SEL_LSB] != freq_sel_r[3:IN_SEL_LSB];
            sys_rl_r <= state_r == RVPS_DONE && section_one_active;
        end
    end

    // Download engine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RVPS_IDLE: if (start_r) state_nxt = RVPS_LOAD;
            RVPS_LOAD: if (dl_cnt_r == 16'(DOWNLOAD_LEN - 1)) state_nxt = RVPS_DONE;
            RVPS_DONE: state_nxt = RVPS_IDLE;
            default:   state_nxt = RVPS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r  <= RVPS_IDLE;
            dl_cnt_r <= 16'h0000;
            start_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dl_cnt_r <= (state_r == RVPS_LOAD) ? dl_cnt_r + 16'h0001 : 16'h0000;
            // A new start in the RVPS_DONE cycle wins over the clear
            if (wr_start && reg_wdata[START_BIT]) begin
                start_r <= 1'b1;
            end else if (state_r == RVPS_DONE) begin
                start_r <= 1'b0;
            end
        end
    end

    // Read mux, reserved bits zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_FORCE_TIMEOUT) rdata_r <= {6'h00, force_r};
            else if (reg_addr == ADDR_MON_OVERRIDE) rdata_r <= {6'h00, override_r};
            else if (reg_addr == ADDR_MON_BYPASS) rdata_r <= {6'h00, bypass_r};
            else if (reg_addr == ADDR_SEC1_ENABLE) rdata_r <= {7'h00, sec1_en_r};
            else if (reg_addr == ADDR_FREQ_SELECT) rdata_r <= freq_sel_r;
            else if (reg_addr == ADDR_SYSPLL_SELECT) rdata_r <= {6'h00, sys_sel_r};
            else if (reg_addr == ADDR_SEC2_ENABLE) rdata_r <= {7'h00, sec2_en_r};
            else if (reg_addr == ADDR_REF_SCALE) rdata_r <= {4'h0, ref_scale_r};
            else if (reg_addr == ADDR_OUT_SCALE) rdata_r <= {4'h0, out_scale_r};
            else if (reg_addr == ADDR_START_TRANSFER) rdata_r <= {7'h00, start_r};
            else rdata_r <= RST_BYTE;
        end else begin
            rdata_r <= RST_BYTE;
        end
    end
    assign reg_rdata = rdata_r;

    // Scale decode
    function automatic logic [4:0] rvps_div(input logic [1:0] code);
        case (rvps_scale_type'(code))
            RVPS_DIV1:  rvps_div = DIV_BY_1;
            RVPS_DIV4:  rvps_div = DIV_BY_4;
            RVPS_DIV8:  rvps_div = DIV_BY_8;
            default:    rvps_div = DIV_BY_16;
        endcase
    endfunction

    // Reference validity and monitor outputs
    assign force_timeout_pulse    = force_r;
    assign ref_fault_eff          = override_r | monitor_fault;
    assign ref_usable             = ~ref_fault_eff;
    assign monitor_bypassed       = bypass_r;
    assign validation_timer_start = bypass_r & ~bypass_d_r;

    // Section gating
    assign hard_pin_mode      = hard_pin_r;
    assign section_one_active = sec1_en_r && !hard_pin_r;
    assign section_two_active = sec2_en_r && !pin_sync_r;
    assign translation_index  = section_one_active ? freq_sel_r : RST_BYTE;
    assign output_reload      = out_rl_r;
    assign input_reload       = in_rl_r;
    assign syspll_reload      = sys_rl_r;
    assign rom_busy           = start_r;

    // System loop setup table
    always_comb begin
        case (sys_sel_r)
            SYS_SEL_CRYSTAL_RESONATOR_LOW: begin
                {syspll_crystal, syspll_doubler} = 2'b11;
                syspll_divider                   = SYS_DIV_16;
            end
            SYS_SEL_CRYSTAL_RESONATOR_HIGH: begin
                {syspll_crystal, syspll_doubler} = 2'b11;
                syspll_divider                   = SYS_DIV_8;
            end
            SYS_SEL_OSC_LOW: begin
                {syspll_crystal, syspll_doubler} = 2'b00;
                syspll_divider                   = SYS_DIV_32;
            end
            default: begin
                {syspll_crystal, syspll_doubler} = 2'b00;
                syspll_divider                   = SYS_DIV_16;
            end
        endcase
    end

    // Dividers apply only with section two live
    assign second_ref_divide   = section_two_active ?
                                 rvps_div(ref_scale_r[3:2]) : DIV_BY_1;
    assign first_ref_divide    = section_two_active ?
                                 rvps_div(ref_scale_r[1:0]) : DIV_BY_1;
    assign channel_one_divide  = section_two_active ?
                                 rvps_div(out_scale_r[3:2]) : DIV_BY_1;
    assign channel_zero_divide = section_two_active ?
                                 rvps_div(out_scale_r[1:0]) : DIV_BY_1;

    // Assertions
    property p_force_clear;
        @(posedge clk) disable iff (sys_rst) force_r != 2'b00 && !wr_force |=> force_r == 2'b00;
    endproperty
    a_force_clear: assert property (p_force_clear) else $error("force bit stuck");

    property p_override_invalid;
        @(posedge clk) disable iff (sys_rst) override_r[0] |-> !ref_usable[0];
    endproperty
    a_override_invalid: assert property (p_override_invalid) else $error("no override");

    property p_timer_start;
        @(posedge clk) disable iff (sys_rst) wr_byp && reg_wdata[1] && !bypass_r[1]
            |=> validation_timer_start[1];
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer not started");

    property p_first_timer;
        @(posedge clk) disable iff (sys_rst) wr_byp && reg_wdata[0] && !bypass_r[0]
            |=> validation_timer_start[0];
    endproperty
    a_first_timer: assert property (p_first_timer) else $error("first timer idle");

    property p_hard_pin;
        @(posedge clk) disable iff (sys_rst) hard_pin_r |-> !section_one_active;
    endproperty
    a_hard_pin: assert property (p_hard_pin) else $error("section one in pin mode");

    property p_index_gated;
        @(posedge clk) disable iff (sys_rst) !section_one_active
            |-> translation_index == RST_BYTE;
    endproperty
    a_index_gated: assert property (p_index_gated) else $error("index leaked");

    property p_start_done;
        @(posedge clk) disable iff (sys_rst) $rose(start_r) |-> ##[1:40] !start_r;
    endproperty
    a_start_done: assert property (p_start_done) else $error("download never ends");

    property p_sec2;
        @(posedge clk) disable iff (sys_rst) !sec2_en_r |-> first_ref_divide == DIV_BY_1;
    endproperty
    a_sec2: assert property (p_sec2) else $error("scale live while disabled");

    property p_scale16;
        @(posedge clk) disable iff (sys_rst) section_two_active && ref_scale_r[3:2] == 2'h3
            |-> second_ref_divide == DIV_BY_16;
    endproperty
    a_scale16: assert property (p_scale16) else $error("bad scale");

    property p_sys;
        @(posedge clk) disable iff (sys_rst) sys_sel_r == 2'h2
            |-> syspll_divider == SYS_DIV_32 && !syspll_doubler;
    endproperty
    a_sys: assert property (p_sys) else $error("bad system setup");

    property p_sec2_pin;
        @(posedge clk) disable iff (sys_rst) pin_sync_r |-> !section_two_active;
    endproperty
    a_sec2_pin: assert property (p_sec2_pin) else $error("section two in pin mode");

    property p_reserved_zero;
        @(posedge clk) disable iff (sys_rst) reg_rd && reg_addr == ADDR_REF_SCALE
            |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");
endmodule

// >>> bench/rvps_bank_test.sv
/*
 * Self-checking bench for the reference validation and preset select bank.
 * Assumes the bank answers reads one cycle after the strobe and that the
 * strap pin is sampled shortly after reset is released.
 */
`timescale 1ns/10ps
module rvps_bank_test;
    import rvps_pkg::*;
    localparam int DL = 4;
    logic        clk;
    logic        sys_rst;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        config_source_select_pin;
    logic [1:0]  monitor_fault;
    logic [1:0]  force_timeout_pulse, ref_fault_eff, ref_usable;
    logic [1:0]  monitor_bypassed, validation_timer_start;
    logic        hard_pin_mode, section_one_active, section_two_active;
    logic [7:0]  translation_index;
    logic        output_reload, input_reload, syspll_reload, rom_busy;
    logic        syspll_doubler, syspll_crystal;
    logic [5:0]  syspll_divider;
    logic [4:0]  first_ref_divide, second_ref_divide;
    logic [4:0]  channel_zero_divide, channel_one_divide;
    int          error_cnt = 0;
    int          comparisons = 0;

    rvps_bank #(.DOWNLOAD_LEN(DL)) u_rvps_bank (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .config_source_select_pin(config_source_select_pin),
        .monitor_fault(monitor_fault), .force_timeout_pulse(force_timeout_pulse),
        .ref_fault_eff(ref_fault_eff), .ref_usable(ref_usable),
        .monitor_bypassed(monitor_bypassed),
        .validation_timer_start(validation_timer_start),
        .hard_pin_mode(hard_pin_mode), .section_one_active(section_one_active),
        .section_two_active(section_two_active),
        .translation_index(translation_index), .output_reload(output_reload),
        .input_reload(input_reload), .syspll_reload(syspll_reload),
        .rom_busy(rom_busy), .syspll_doubler(syspll_doubler),
        .syspll_crystal(syspll_crystal), .syspll_divider(syspll_divider),
        .first_ref_divide(first_ref_divide), .second_ref_divide(second_ref_divide),
        .channel_zero_divide(channel_zero_divide),
        .channel_one_divide(channel_one_divide));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wrap_up;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic do_reset(input logic pin);
        @(posedge clk);
        config_source_select_pin <= pin;
        sys_rst <= 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    function automatic logic [4:0] div_of(input int k);
        case (k)
            0: return 5'h01;
            1: return 5'h04;
            2: return 5'h08;
            default: return 5'h10;
        endcase
    endfunction

    task automatic t_reset_values;
        rd(ADDR_MON_OVERRIDE, 8'h00);
        rd(ADDR_MON_BYPASS, 8'h00);
        rd(ADDR_SEC1_ENABLE, 8'h00);
        rd(ADDR_SEC2_ENABLE, 8'h00);
        rd(ADDR_REF_SCALE, 8'h00);
        rd(ADDR_OUT_SCALE, 8'h00);
        check(8'(first_ref_divide), 8'h01);
    endtask

    task automatic t_bypass_then_force;
        wr(ADDR_MON_BYPASS, 8'h02);
        check(8'(monitor_bypassed), 8'h02);
        check(8'(validation_timer_start), 8'h02);
        @(posedge clk);
        #1;
        check(8'(validation_timer_start), 8'h00);
        wr(ADDR_FORCE_TIMEOUT, 8'h02);
        check(8'(force_timeout_pulse), 8'h02);
        @(posedge clk);
        #1;
        check(8'(force_timeout_pulse), 8'h00);
        wr(ADDR_FORCE_TIMEOUT, 8'h01);
        check(8'(force_timeout_pulse), 8'h01);
    endtask

    task automatic t_override;
        @(posedge clk);
        monitor_fault <= 2'b10;
        wr(ADDR_MON_OVERRIDE, 8'h01);
        check(8'(ref_fault_eff), 8'h03);
        check(8'(ref_usable), 8'h00);
        wr(ADDR_MON_OVERRIDE, 8'hfe);
        @(posedge clk);
        monitor_fault <= 2'b00;
        rd(ADDR_MON_OVERRIDE, 8'h02);
        check(8'(ref_usable), 8'h01);
        wr(ADDR_MON_OVERRIDE, 8'h00);
        check(8'(ref_usable), 8'h03);
    endtask

    task automatic t_section_one;
        wr(ADDR_FREQ_SELECT, 8'h5a);
        check(translation_index, 8'h00);
        wr(ADDR_SEC1_ENABLE, 8'hff);
        rd(ADDR_SEC1_ENABLE, 8'h01);
        check(translation_index, 8'h5a);
        wr(ADDR_FREQ_SELECT, 8'h6a);
        check({6'h0, output_reload, input_reload}, 8'h02);
        wr(ADDR_FREQ_SELECT, 8'h6b);
        check({6'h0, output_reload, input_reload}, 8'h01);
    endtask

    task automatic t_syspll;
        int          fall;
        logic        seen;
        logic [7:0]  exp_div [4] = '{8'h10, 8'h08, 8'h20, 8'h10};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_SYSPLL_SELECT, 8'(i));
            check(8'(syspll_divider), exp_div[i]);
            check({6'h0, syspll_crystal, syspll_doubler}, (i < 2) ? 8'h03 : 8'h00);
        end
        wr(ADDR_START_TRANSFER, 8'h01);
        check(8'(rom_busy), 8'h01);
        fall = 0;
        seen = 1'b0;
        for (int n = 1; n <= DL + 8; n++) begin
            @(posedge clk);
            #1;
            if (syspll_reload === 1'b1) seen = 1'b1;
            if (fall == 0 && rom_busy === 1'b0) fall = n;
        end
        check(8'(fall >= DL && fall <= DL + 3), 8'h01);
        check(8'(seen), 8'h01);
        rd(ADDR_SYSPLL_SELECT, 8'h03);
    endtask

    task automatic t_scale;
        wr(ADDR_REF_SCALE, 8'h0f);
        check(8'(second_ref_divide), 8'h01);
        wr(ADDR_SEC2_ENABLE, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_REF_SCALE, 8'(k * 4 + 3 - k) | 8'hf0);
            wr(ADDR_OUT_SCALE, 8'(k * 4 + 3 - k));
            check(8'(second_ref_divide), 8'(div_of(k)));
            check(8'(first_ref_divide), 8'(div_of(3 - k)));
            check(8'(channel_one_divide), 8'(div_of(k)));
            check(8'(channel_zero_divide), 8'(div_of(3 - k)));
        end
        rd(ADDR_REF_SCALE, 8'h0c);
    endtask

    task automatic t_unmapped;
        wr(12'h123, 8'ha5);
        rd(12'h123, 8'h00);
    endtask

    task automatic t_hard_pin;
        do_reset(1'b1);
        wr(ADDR_SEC1_ENABLE, 8'h01);
        wr(ADDR_FREQ_SELECT, 8'h33);
        check({6'h0, hard_pin_mode, section_one_active}, 8'h02);
        check(translation_index, 8'h00);
        wr(ADDR_SEC2_ENABLE, 8'h01);
        wr(ADDR_REF_SCALE, 8'h0f);
        check(8'(first_ref_divide), 8'h01);
    endtask

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        config_source_select_pin = 1'b0;
        monitor_fault = 2'b00;
        do_reset(1'b0);
        t_reset_values();
        t_bypass_then_force();
        t_override();
        t_section_one();
        t_syspll();
        t_scale();
        t_unmapped();
        t_hard_pin();
        wrap_up();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule
